// File: core/cct_channel.sv
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - clear bit zeroes count, divider, direction
// - clear bit self-clears, always reads zero
// - overflow enable gates overflow request
// - overflow flag shows pending overflow
// - count register holds sixteen-bit count
// - compare value moves to latch, compared
// - capture copies count into compare value
// - sync bit: immediate or timer-tick capture
// - latch load 01: load at zero
// - latch load 10: zero, or latch0 in up/down mode
// - channel enable gates channel request
// - input bit shows selected input level
// - output mode zero follows output bit
// - capture overflow sticky until software clears
// - channel flag shows pending channel event
// - vector returns highest-priority pending code
//////////////////////////////////////////////////////////////////////////////
package cct_pkg;
   // sizes
   localparam int CCT_NCH = 7;
   localparam int CCT_CW = 16;
   // register byte offsets on the plain register port
   localparam logic [7:0] CCT_OFS_CTL = 8'h00;
   localparam logic [7:0] CCT_OFS_CHCTL0 = 8'h02;
   localparam logic [7:0] CCT_OFS_COUNT = 8'h10;
   localparam logic [7:0] CCT_OFS_CCR0 = 8'h20;
   localparam logic [7:0] CCT_OFS_VECTOR = 8'h30;
   localparam logic [7:0] CCT_OFS_STEP = 8'h02;
   // timer control field positions
   localparam int CCT_CTL_FLAG = 0;
   localparam int CCT_CTL_IE = 1;
   localparam int CCT_CTL_CLR = 2;
   localparam int CCT_CTL_MODE = 4;
   localparam int CCT_CTL_DIV = 6;
   localparam logic [15:0] CCT_CTL_RST = 16'h0000;
   localparam logic [15:0] CCT_CHCTL_RST = 16'h0000;
   localparam logic [15:0] CCT_CCR_RST = 16'h0000;
   // count modes
   localparam logic [1:0] CCT_MODE_STOP = 2'h0;
   localparam logic [1:0] CCT_MODE_UP = 2'h1;
   localparam logic [1:0] CCT_MODE_CONT = 2'h2;
   localparam logic [1:0] CCT_MODE_UPDOWN = 2'h3;
   // capture edge codes
   localparam logic [1:0] CCT_EDGE_NONE = 2'h0;
   localparam logic [1:0] CCT_EDGE_RISE = 2'h1;
   localparam logic [1:0] CCT_EDGE_FALL = 2'h2;
   localparam logic [1:0] CCT_EDGE_BOTH = 2'h3;
   // capture input routing
   localparam logic [1:0] CCT_IN_A = 2'h0;
   localparam logic [1:0] CCT_IN_B = 2'h1;
   localparam logic [1:0] CCT_IN_LOW = 2'h2;
   localparam logic [1:0] CCT_IN_HIGH = 2'h3;
   // latch load conditions
   localparam logic [1:0] CCT_LD_WRITE = 2'h0;
   localparam logic [1:0] CCT_LD_ZERO = 2'h1;
   localparam logic [1:0] CCT_LD_ZERO_L0 = 2'h2;
   localparam logic [1:0] CCT_LD_L0 = 2'h3;
   // output modes
   localparam logic [2:0] CCT_OM_BIT = 3'h0;
   localparam logic [2:0] CCT_OM_SET = 3'h1;
   localparam logic [2:0] CCT_OM_TOG_RST = 3'h2;
   localparam logic [2:0] CCT_OM_SET_RST = 3'h3;
   localparam logic [2:0] CCT_OM_TOGGLE = 3'h4;
   localparam logic [2:0] CCT_OM_RESET = 3'h5;
   localparam logic [2:0] CCT_OM_TOG_SET = 3'h6;
   localparam logic [2:0] CCT_OM_RST_SET = 3'h7;
   // vector codes
   localparam logic [15:0] CCT_VEC_NONE = 16'h0000;
   localparam logic [15:0] CCT_VEC_OVF = 16'h000E;
   // channel control word, laid out as the register bits
   typedef struct packed {
      logic [1:0] captureEdgeSelect;
      logic [1:0] captureInputSelect;
      logic captureSyncSelect;
      logic [1:0] latchLoadSelect;
      logic captureSelect;
      logic [2:0] outputModeSelect;
      logic channelIrqEnable;
      logic channelInputLevel;
      logic outBit;
      logic captureOverflow;
      logic channelFlag;
   } cct_chctl_type;
endpackage : cct_pkg

`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// one capture/compare channel
module cct_channel
   import cct_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // timer state
   input wire logic tick,
   input wire logic [cct_pkg::CCT_CW-1:0] count,
   input wire logic zeroEvt,
   input wire logic latchZeroEvt,
   input wire logic upDownMode,
   input wire logic channelZeroMatch,
   // software access
   input wire logic wrCtl,
   input wire logic wrCcr,
   input wire logic [15:0] wrData,
   input wire logic clrFlag,
   // capture inputs
   input wire logic captureInputA,
   input wire logic captureInputB,
   // results
   output cct_pkg::cct_chctl_type ctlRd,
   output logic [cct_pkg::CCT_CW-1:0] ccrRd,
   output logic [cct_pkg::CCT_CW-1:0] latchRd,
   output logic channelMatch,
   output logic chanOut
);
   cct_chctl_type ctl_ff; // control word, input level slot unused
   logic [CCT_CW-1:0] ccr_ff; // capture/compare value
   logic [CCT_CW-1:0] latch_ff; // compare latch
   logic prevIn_ff; // last input level for edge detection
   logic capPend_ff; // capture waiting for the timer tick
   logic matchPrev_ff; // equality one cycle ago
   logic out_ff; // output unit state
   cct_chctl_type wrCtlWord;
   logic selIn, rise, fall, capEdge, doCapture, matchNow, loadNow, nxt_out;

   assign wrCtlWord = cct_chctl_type'(wrData);
   // input routing
   assign selIn = (ctl_ff.captureInputSelect == CCT_IN_A) ? captureInputA :
                  (ctl_ff.captureInputSelect == CCT_IN_B) ? captureInputB :
                  (ctl_ff.captureInputSelect == CCT_IN_HIGH);
   assign rise = selIn & ~prevIn_ff;
   assign fall = ~selIn & prevIn_ff;
   // edge qualification only in capture mode
   assign capEdge = ctl_ff.captureSelect &
      (((ctl_ff.captureEdgeSelect == CCT_EDGE_RISE) & rise) |
       ((ctl_ff.captureEdgeSelect == CCT_EDGE_FALL) & fall) |
       ((ctl_ff.captureEdgeSelect == CCT_EDGE_BOTH) & (rise | fall)));
   // sync capture waits for the tick so the count is settled
   assign doCapture = ctl_ff.captureSyncSelect ? ((capEdge | capPend_ff) & tick) : capEdge;
   assign matchNow = ~ctl_ff.captureSelect & (count == latch_ff);
   assign channelMatch = matchNow & ~matchPrev_ff;
   // latch load condition
   assign loadNow = ~ctl_ff.captureSelect & (
      ((ctl_ff.latchLoadSelect == CCT_LD_WRITE) & wrCcr) |
      ((ctl_ff.latchLoadSelect == CCT_LD_ZERO) & zeroEvt) |
      ((ctl_ff.latchLoadSelect == CCT_LD_ZERO_L0) & (zeroEvt | (upDownMode & latchZeroEvt))) |
      ((ctl_ff.latchLoadSelect == CCT_LD_L0) & latchZeroEvt));

   // output unit
   always_comb
   begin
      nxt_out = out_ff;
      case (ctl_ff.outputModeSelect)
         CCT_OM_BIT: nxt_out = ctl_ff.outBit;
         CCT_OM_SET: if (channelMatch) nxt_out = 1'b1;
         CCT_OM_TOG_RST: nxt_out = channelMatch ? ~out_ff : (channelZeroMatch ? 1'b0 : out_ff);
         CCT_OM_SET_RST: nxt_out = channelMatch ? 1'b1 : (channelZeroMatch ? 1'b0 : out_ff);
         CCT_OM_TOGGLE: if (channelMatch) nxt_out = ~out_ff;
         CCT_OM_RESET: if (channelMatch) nxt_out = 1'b0;
         CCT_OM_TOG_SET: nxt_out = channelMatch ? ~out_ff : (channelZeroMatch ? 1'b1 : out_ff);
         CCT_OM_RST_SET: nxt_out = channelMatch ? 1'b0 : (channelZeroMatch ? 1'b1 : out_ff);
         default: nxt_out = out_ff;
      endcase
   end

   // control word; hardware sets win over software clears
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         ctl_ff <= cct_chctl_type'(CCT_CHCTL_RST);
      else
      begin
         if (wrCtl)
            ctl_ff <= wrCtlWord;
         ctl_ff.channelInputLevel <= 1'b0;
         ctl_ff.captureOverflow <= (doCapture & ctl_ff.channelFlag) |
            (wrCtl ? wrCtlWord.captureOverflow : ctl_ff.captureOverflow);
         ctl_ff.channelFlag <= doCapture | channelMatch |
            (~clrFlag & (wrCtl ? wrCtlWord.channelFlag : ctl_ff.channelFlag));
      end
   end

   // value, latch and history
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         ccr_ff <= CCT_CCR_RST;
         latch_ff <= CCT_CCR_RST;
         prevIn_ff <= 1'b0;
         capPend_ff <= 1'b0;
         // count and latch both leave reset at zero, so equality already stands;
         // starting high keeps that idle equality from posing as a fresh match
         matchPrev_ff <= 1'b1;
         out_ff <= 1'b0;
      end
      else
      begin
         if (doCapture)
            ccr_ff <= count;
         else if (wrCcr)
            ccr_ff <= wrData;
         if (loadNow)
            latch_ff <= wrCcr ? wrData : ccr_ff;
         prevIn_ff <= selIn;
         capPend_ff <= ctl_ff.captureSyncSelect & ~tick & (capEdge | capPend_ff);
         matchPrev_ff <= matchNow;
         out_ff <= nxt_out;
      end
   end

   // readback with live input level
   always_comb
   begin
      ctlRd = ctl_ff;
      ctlRd.channelInputLevel = selIn;
   end
   assign ccrRd = ccr_ff;
   assign latchRd = latch_ff;
   assign chanOut = out_ff;
endmodule : cct_channel

// File: core/cct_timer.sv
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// sixteen-bit capture/compare timer, top level
// the timer counts on a divided enable derived from sys_clk; all channel
// logic shares one clock so no crossing is needed anywhere
module cct_timer
   import cct_pkg::*;
#(
   parameter int NCH = cct_pkg::CCT_NCH
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [15:0] regRdData,
   // capture inputs
   input wire logic [NCH-1:0] captureInputA,
   input wire logic [NCH-1:0] captureInputB,
   // outputs
   output logic [NCH-1:0] channelOut,
   output logic [NCH-1:0] channelRequest,
   output logic overflowRequest
);
   //////////////////////////////////////////////////////////////////////////
   // helper functions

   // byte offset of a per-channel register
   function automatic logic [7:0] cct_ofs(input logic [7:0] base, input int idx);
      cct_ofs = base + 8'(idx * 2);
   endfunction : cct_ofs

   // terminal value of the input divider for a divide select
   function automatic logic [2:0] cct_div_max(input logic [1:0] sel);
      case (sel)
         2'h0: cct_div_max = 3'h0;
         2'h1: cct_div_max = 3'h1;
         2'h2: cct_div_max = 3'h3;
         default: cct_div_max = 3'h7;
      endcase
   endfunction : cct_div_max

   //////////////////////////////////////////////////////////////////////////
   // state

   logic ovfFlag_ff; // overflow flag
   logic ovfIe_ff; // overflow request enable
   logic [1:0] mode_ff; // count mode
   logic [1:0] divSel_ff; // input divider select
   logic [CCT_CW-1:0] count_ff; // running count
   logic down_ff; // up/down direction, set while counting down
   logic [2:0] divCnt_ff; // input divider counter
   logic [15:0] rdData_ff; // registered read data

   // per-channel wires
   cct_chctl_type chCtl [NCH];
   logic [CCT_CW-1:0] chCcr [NCH];
   logic [CCT_CW-1:0] chLatch [NCH];
   logic [NCH-1:0] chMatch;
   logic [NCH-1:0] wrCtlCh;
   logic [NCH-1:0] wrCcrCh;
   logic [NCH-1:0] vecClrCh;
   logic [NCH-1:0] chPend;

   //////////////////////////////////////////////////////////////////////////
   // address decode

   logic wrTimerCtl, wrCount, rdVector, clearReq;
   assign wrTimerCtl = regWrEn & (regAddr == CCT_OFS_CTL);
   assign wrCount = regWrEn & (regAddr == CCT_OFS_COUNT);
   assign rdVector = regRdEn & (regAddr == CCT_OFS_VECTOR);
   // clear bit acts on the write, it is never stored
   assign clearReq = wrTimerCtl & regWrData[CCT_CTL_CLR];

   //////////////////////////////////////////////////////////////////////////
   // input divider and timer tick

   logic divEnd, tick, running;
   // stop mode freezes the divider so the phase survives a pause
   assign running = (mode_ff != CCT_MODE_STOP);
   assign divEnd = (divCnt_ff == cct_div_max(divSel_ff));
   assign tick = running & divEnd & ~clearReq;

   // divider counter
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         divCnt_ff <= 3'h0;
      else if (clearReq)
         divCnt_ff <= 3'h0;
      else if (running)
         divCnt_ff <= divEnd ? 3'h0 : divCnt_ff + 3'h1;
   end

   //////////////////////////////////////////////////////////////////////////
   // counter

   logic [CCT_CW-1:0] latchZero; // channel_zero_latch
   logic [CCT_CW-1:0] countInc, countDec, nxt_count;
   logic nxt_down;
   assign latchZero = chLatch[0];
   assign countInc = count_ff + 16'h0001;
   assign countDec = count_ff - 16'h0001;

   // next count on a tick, per mode
   always_comb
   begin
      nxt_count = count_ff;
      nxt_down = down_ff;
      case (mode_ff)
         CCT_MODE_UP:
         begin
            // up to channel_zero_latch, then restart at zero
            nxt_count = (count_ff >= latchZero) ? 16'h0000 : countInc;
         end
         CCT_MODE_CONT:
         begin
            // full sixteen-bit roll-over
            nxt_count = countInc;
         end
         CCT_MODE_UPDOWN:
         begin
            if (down_ff)
            begin
               nxt_count = (count_ff == 16'h0000) ? 16'h0000 : countDec;
               nxt_down = (countDec != 16'h0000) & (count_ff != 16'h0000);
            end
            else if (count_ff >= latchZero)
            begin
               // a zero latch would stall here; stays at zero
               nxt_count = (count_ff == 16'h0000) ? 16'h0000 : countDec;
               nxt_down = (count_ff > 16'h0001);
            end
            else
               nxt_count = countInc;
         end
         default:
         begin
            nxt_count = count_ff;
            nxt_down = down_ff;
         end
      endcase
   end

   // events seen by the channels and the overflow flag
   logic zeroEvt, latchZeroEvt, ovfEvt;
   assign zeroEvt = tick & (nxt_count == 16'h0000);
   assign latchZeroEvt = tick & (nxt_count == latchZero);
   // overflow is the step into zero from a non-zero count
   assign ovfEvt = zeroEvt & (count_ff != 16'h0000);

   // count and direction
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         count_ff <= 16'h0000;
         down_ff <= 1'b0;
      end
      else if (clearReq)
      begin
         count_ff <= 16'h0000;
         down_ff <= 1'b0;
      end
      else if (wrCount)
         count_ff <= regWrData;
      else if (tick)
      begin
         count_ff <= nxt_count;
         down_ff <= nxt_down;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // pending source vector

   // lowest channel from one upward wins, overflow last
   logic [15:0] vecCode;
   logic vecOvf;
   always_comb
   begin
      vecCode = CCT_VEC_NONE;
      vecOvf = 1'b0;
      vecClrCh = '0;
      if (overflowRequest)
      begin
         vecCode = CCT_VEC_OVF;
         vecOvf = 1'b1;
      end
      for (int i = NCH - 1; i >= 1; i--)
      begin
         if (chPend[i])
         begin
            vecCode = 16'(i * 2);
            vecOvf = 1'b0;
            vecClrCh = '0;
            vecClrCh[i] = rdVector;
         end
      end
   end

   // channel zero has no vector code, only a software clear
   logic vecClrOvf;
   assign vecClrOvf = rdVector & vecOvf;

   //////////////////////////////////////////////////////////////////////////
   // timer control register

   // hardware overflow set wins over any clear in the same cycle
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         ovfFlag_ff <= CCT_CTL_RST[CCT_CTL_FLAG];
         ovfIe_ff <= CCT_CTL_RST[CCT_CTL_IE];
         mode_ff <= CCT_CTL_RST[CCT_CTL_MODE +: 2];
         divSel_ff <= CCT_CTL_RST[CCT_CTL_DIV +: 2];
      end
      else
      begin
         ovfFlag_ff <= ovfEvt | (~vecClrOvf &
            (wrTimerCtl ? regWrData[CCT_CTL_FLAG] : ovfFlag_ff));
         if (wrTimerCtl)
         begin
            ovfIe_ff <= regWrData[CCT_CTL_IE];
            mode_ff <= regWrData[CCT_CTL_MODE +: 2];
            divSel_ff <= regWrData[CCT_CTL_DIV +: 2];
         end
      end
   end

   assign overflowRequest = ovfFlag_ff & ovfIe_ff;

   //////////////////////////////////////////////////////////////////////////
   // channels

   generate
      for (genvar g = 0; g < NCH; g++)
      begin : gen_ch
         // per-channel decode
         assign wrCtlCh[g] = regWrEn & (regAddr == cct_ofs(CCT_OFS_CHCTL0, g));
         assign wrCcrCh[g] = regWrEn & (regAddr == cct_ofs(CCT_OFS_CCR0, g));
         assign chPend[g] = chCtl[g].channelFlag & chCtl[g].channelIrqEnable;

         cct_channel u_channel
         (
            .sys_clk(sys_clk),
            .reset(reset),
            .tick(tick),
            .count(count_ff),
            .zeroEvt(zeroEvt),
            .latchZeroEvt(latchZeroEvt),
            .upDownMode(mode_ff == CCT_MODE_UPDOWN),
            .channelZeroMatch(chMatch[0]),
            .wrCtl(wrCtlCh[g]),
            .wrCcr(wrCcrCh[g]),
            .wrData(regWrData),
            .clrFlag(vecClrCh[g]),
            .captureInputA(captureInputA[g]),
            .captureInputB(captureInputB[g]),
            .ctlRd(chCtl[g]),
            .ccrRd(chCcr[g]),
            .latchRd(chLatch[g]),
            .channelMatch(chMatch[g]),
            .chanOut(channelOut[g])
         );
      end
   endgenerate

   assign channelRequest = chPend;

   //////////////////////////////////////////////////////////////////////////
   // read path

   // combinational select, registered so data stands one cycle later
   logic [15:0] rdSel;
   always_comb
   begin
      rdSel = 16'h0000;
      if (regAddr == CCT_OFS_CTL)
      begin
         rdSel[CCT_CTL_FLAG] = ovfFlag_ff;
         rdSel[CCT_CTL_IE] = ovfIe_ff;
         rdSel[CCT_CTL_CLR] = 1'b0;
         rdSel[CCT_CTL_MODE +: 2] = mode_ff;
         rdSel[CCT_CTL_DIV +: 2] = divSel_ff;
      end
      else if (regAddr == CCT_OFS_COUNT)
         rdSel = count_ff;
      else if (regAddr == CCT_OFS_VECTOR)
         rdSel = vecCode;
      for (int i = 0; i < NCH; i++)
      begin
         if (regAddr == cct_ofs(CCT_OFS_CHCTL0, i))
            rdSel = 16'(chCtl[i]);
         if (regAddr == cct_ofs(CCT_OFS_CCR0, i))
            rdSel = chCcr[i];
      end
   end

   // read data register; unmapped addresses answer zero
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         rdData_ff <= 16'h0000;
      else if (regRdEn)
         rdData_ff <= rdSel;
      else
         rdData_ff <= 16'h0000;
   end

   assign regRdData = rdData_ff;
endmodule : cct_timer

// File: bench/cct_timer_monitor.sv
`timescale 1ns/1ps
//////////////////////////////////////////
// watches the register port and the request outputs of the timer
module cct_timer_monitor
   import cct_pkg::*;
#(
   parameter int NCH = cct_pkg::CCT_NCH
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [15:0] regRdData,
   // outputs
   input wire logic [NCH-1:0] channelOut,
   input wire logic [NCH-1:0] channelRequest,
   input wire logic overflowRequest
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // decoded accesses
   wire logic vecRd = regRdEn && regAddr == CCT_OFS_VECTOR;
   wire logic ctlWr = regWrEn && regAddr == CCT_OFS_CTL;
   wire logic ch1Wr = regWrEn && regAddr == CCT_OFS_CHCTL0 + CCT_OFS_STEP;
   // no channel request below the overflow
   wire logic chIdle = channelRequest[6:1] == 6'h00;
   logic outBit_ff; // out bit last written to channel one
   // remember the out bit so the mode zero output can be judged later
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         outBit_ff <= 1'b0;
      else if (ch1Wr)
         outBit_ff <= regWrData[2];
   end
   // read data stands one cycle only, else zero
   a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 16'h0000)
      else $error("read data not zero outside read slot");
   a_clr_reads_zero: assert property (regRdEn && regAddr == CCT_OFS_CTL |=> !regRdData[CCT_CTL_CLR])
      else $error("clear bit read as one");
   a_vec_layout: assert property (vecRd |=> regRdData[15:4] == 12'h000 && !regRdData[0])
      else $error("vector code outside bits three to one");
   a_vec_none: assert property (vecRd && chIdle && !overflowRequest |=> regRdData == CCT_VEC_NONE)
      else $error("vector not empty with nothing pending");
   a_vec_ovf: assert property (vecRd && chIdle && overflowRequest |=> regRdData == CCT_VEC_OVF)
      else $error("vector missed lone overflow");
   a_vec_first: assert property (vecRd && channelRequest[1] |=> regRdData == 16'h0002)
      else $error("channel one not given first");
   a_ovf_gate: assert property (ctlWr && !regWrData[CCT_CTL_IE] |=> !overflowRequest)
      else $error("overflow request while disabled");
   a_ovf_flag_wr: assert property (ctlWr && regWrData[1:0] == 2'h3 |=> overflowRequest)
      else $error("pending overflow not requested");
   a_ch_gate: assert property (ch1Wr && !regWrData[4] |=> !channelRequest[1])
      else $error("channel request while disabled");
   a_out_follow: assert property (ch1Wr && regWrData[7:5] == CCT_OM_BIT |-> ##[1:2] channelOut[1] == outBit_ff)
      else $error("mode zero output not following out bit");
endmodule : cct_timer_monitor

bind cct_timer cct_timer_monitor #(.NCH(NCH)) u_mon (.sys_clk, .reset, .regAddr, .regWrData, .regWrEn,
   .regRdEn, .regRdData, .channelOut, .channelRequest, .overflowRequest);

// File: bench/tb_top.sv
`timescale 1ns/1ps
//////////////////////////////////////////
// drives the timer through its register port, checks reads and outputs
module tb_top;
   import cct_pkg::*;
   localparam int NCH = 7;
   localparam int TIMEOUT = 20000; // run needs well under a thousand cycles
   // clock and reset
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   // register port
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [15:0] regRdData;
   // capture inputs and results
   logic [NCH-1:0] captureInputA = '0;
   logic [NCH-1:0] captureInputB = '0;
   logic [NCH-1:0] channelOut;
   logic [NCH-1:0] channelRequest;
   logic overflowRequest;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [15:0] rdVal;
   // output after one match, channel n in mode n, no channel zero match
   logic [NCH-1:0] outExp = 7'h5e;

   cct_timer #(.NCH(NCH)) dut (.sys_clk, .reset, .regAddr, .regWrData, .regWrEn, .regRdEn,
      .regRdData, .captureInputA, .captureInputB, .channelOut, .channelRequest, .overflowRequest);

   // 25 MHz
   always #20 sys_clk = ~sys_clk;

   // hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == TIMEOUT)
      begin
         fails++;
         complete_run();
      end
   end

   //////////////////////////////////////////
   function automatic logic [7:0] chAdr(input int n);
      return CCT_OFS_CHCTL0 + CCT_OFS_STEP * 8'(n);
   endfunction : chAdr
   function automatic logic [7:0] ccrAdr(input int n);
      return CCT_OFS_CCR0 + CCT_OFS_STEP * 8'(n);
   endfunction : ccrAdr
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask : wr
   // data is only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1;
      d = regRdData;
   endtask : rd
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
      rd(a, rdVal);
      chk(name, exp, rdVal);
   endtask : rdchk
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   //////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      // reset values, unmapped read
      rdchk("ctl reset", CCT_OFS_CTL, CCT_CTL_RST);
      rdchk("ccr1 reset", ccrAdr(1), CCT_CCR_RST);
      rdchk("unmapped", 8'hfe, 16'h0000);
      // count access and clear
      wr(CCT_OFS_COUNT, 16'h5a5a);
      rdchk("count", CCT_OFS_COUNT, 16'h5a5a);
      wr(CCT_OFS_CTL, 16'h0004);
      rdchk("clear bit", CCT_OFS_CTL, 16'h0000);
      rdchk("count cleared", CCT_OFS_COUNT, 16'h0000);
      // overflow across the wrap, continuous /1
      wr(CCT_OFS_COUNT, 16'hfffc);
      wr(CCT_OFS_CTL, 16'h0022);
      repeat (8) @(posedge sys_clk);
      rdchk("ovf flag", CCT_OFS_CTL, 16'h0023);
      wr(CCT_OFS_CTL, 16'h0021);
      #1 chk("ovf masked", 16'h0000, {15'h0000, overflowRequest});
      wr(CCT_OFS_CTL, 16'h0023);
      rdchk("vector ovf", CCT_OFS_VECTOR, CCT_VEC_OVF);
      rdchk("ovf taken", CCT_OFS_CTL, 16'h0022);
      // compare: one match on channels one to six, mode n on channel n
      wr(CCT_OFS_CTL, 16'h0004);
      wr(ccrAdr(0), 16'h0100);
      for (int n = 1; n < 7; n++)
         wr(ccrAdr(n), 16'h0005);
      for (int n = 1; n < 7; n++)
         wr(chAdr(n), {8'h00, 3'(n), 5'h10});
      wr(CCT_OFS_CTL, 16'h0020);
      repeat (12) @(posedge sys_clk);
      wr(CCT_OFS_CTL, 16'h0000);
      #1 chk("outputs", {9'h000, outExp}, {9'h000, channelOut});
      chk("requests", 16'h007e, {9'h000, channelRequest});
      rdchk("ccr1 kept", ccrAdr(1), 16'h0005);
      for (int n = 1; n < 7; n++)
         rdchk("vector", CCT_OFS_VECTOR, 16'(2 * n));
      rdchk("vector empty", CCT_OFS_VECTOR, CCT_VEC_NONE);
      // mode zero follows the out bit
      for (int b = 0; b < 2; b++)
      begin
         wr(chAdr(1), {13'h0000, 1'(b), 2'h0});
         @(posedge sys_clk);
         #1 chk("out bit", 16'(b), {15'h0000, channelOut[1]});
      end
      // asynchronous capture on a rising edge of input a, timer stopped
      wr(CCT_OFS_COUNT, 16'h0abc);
      wr(chAdr(1), 16'h4110);
      captureInputA[1] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk("capture", ccrAdr(1), 16'h0abc);
      rdchk("capture flag", chAdr(1), 16'h4119);
      @(posedge sys_clk);
      captureInputA[1] <= 1'b0;
      repeat (2) @(posedge sys_clk);
      captureInputA[1] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk("cap overflow", chAdr(1), 16'h411b);
      wr(chAdr(1), 16'h4110);
      rdchk("cov cleared", chAdr(1), 16'h4118);
      // input routing seen on the level bit
      captureInputB[2] <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         wr(chAdr(2), {2'h0, 2'(s), 12'h000});
         rdchk("input level", chAdr(2), {2'h0, 2'(s), 8'h00, s[0], 3'h0});
      end
      // synchronous capture waits for a timer tick
      wr(chAdr(3), 16'h4910);
      captureInputA[3] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk("sync held", 16'h0000, {15'h0000, channelRequest[3]});
      wr(CCT_OFS_CTL, 16'h00e0);
      repeat (10) @(posedge sys_clk);
      #1 chk("sync taken", 16'h0001, {15'h0000, channelRequest[3]});
      wr(CCT_OFS_CTL, 16'h0000);
      // load at zero: a value written before the wrap must not match before it,
      // and the old latch value 5 must be gone once the count passes zero
      wr(chAdr(4), 16'h0210);
      wr(chAdr(5), 16'h0410);
      wr(ccrAdr(4), 16'hffff);
      wr(ccrAdr(5), 16'hffff);
      wr(CCT_OFS_COUNT, 16'hfffc);
      wr(CCT_OFS_CTL, 16'h0020);
      repeat (12) @(posedge sys_clk);
      #1 chk("load at zero", 16'h0000, {15'h0000, channelRequest[4]});
      chk("load zero or l0", 16'h0000, {15'h0000, channelRequest[5]});
      complete_run();
   end
endmodule : tb_top
